// ==== core/lrc_pkg.sv ====
package lrc_pkg;

    // ========================================================
    // bus geometry
    localparam int          DATA_W    = 18;
    localparam int          PIN_W     = 28;
    localparam int          BEAT_W    = 2;

    // ========================================================
    // index values with a fixed meaning
    localparam logic [7:0]  IDX_FRAME  = 8'h22;
    localparam logic [7:0]  IDX_PIXFMT = 8'h3A;

    // ========================================================
    // bus-width strap codes {hi, mid, lo}
    localparam logic [2:0]  BW_16_65K  = 3'h0;
    localparam logic [2:0]  BW_16P2_A  = 3'h1;
    localparam logic [2:0]  BW_18_A    = 3'h2;
    localparam logic [2:0]  BW_8       = 3'h3;
    localparam logic [2:0]  BW_16P2_B  = 3'h4;
    localparam logic [2:0]  BW_18_B    = 3'h5;

    // ========================================================
    // serial pixel format field, low bits of the 3Ah register
    localparam logic [2:0]  FMT_565    = 3'h5;
    localparam logic [2:0]  FMT_RST    = 3'h6;

    // ========================================================
    // reset values
    localparam logic [27:0] PIN_RST    = 28'h800_0000;
    localparam logic [17:0] PIX_RST    = 18'h0_0000;
    localparam logic [7:0]  INDEX_RST  = 8'h00;
    localparam logic [15:0] WORD_RST   = 16'h0000;
    localparam logic [1:0]  CNT_RST    = 2'h0;
    localparam logic [2:0]  BIT_RST    = 3'h0;
    localparam logic [7:0]  BYTE_RST   = 8'h00;

    typedef enum logic [1:0] {
        PAR_IDLE  = 2'b00,
        PAR_WRITE = 2'b01,
        PAR_READ  = 2'b10
    } lrc_par_t;

    typedef enum logic [1:0] {
        SER_START = 2'b00,
        SER_WRITE = 2'b01,
        SER_SKIP  = 2'b10
    } lrc_ser_t;

endpackage : lrc_pkg

// ==== core/lrc_host_port.sv ====
`timescale 1ns/10ps

module lrc_host_port #(
    parameter logic [4:0] SER_DEV_CODE = 5'h15  // arbitrary value
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        host_protocol_strap_i,
    input  wire logic        cpu_family_strap_i,
    input  wire logic        bus_width_strap_hi_i,
    input  wire logic        bus_width_strap_mid_i,
    input  wire logic        bus_width_strap_lo_i,
    input  wire logic        chip_select_low_n_i,
    input  wire logic        index_data_select_i,
    input  wire logic        write_strobe_or_enable_i,
    input  wire logic        read_strobe_or_direction_i,
    input  wire logic [17:0] parallel_data_lines_i,
    input  wire logic        serial_data_i,
    input  wire logic        otp_video_enable_i,
    input  wire logic        partial_mode_i,
    input  wire logic [17:0] video_pixel_i,
    input  wire logic [17:0] frame_pixel_i,
    input  wire logic [17:0] fm_rdata_i,
    input  wire logic [15:0] reg_rdata_i,
    input  wire logic [15:0] status_i,
    output logic      [17:0] parallel_data_lines_o,
    output logic             parallel_data_lines_oe_o,
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic      [7:0]  reg_index_o,
    output logic      [15:0] reg_wdata_o,
    output logic             fm_wr_o,
    output logic      [17:0] fm_wdata_o,
    output logic             fm_rd_o,
    output logic      [17:0] display_pixel_o,
    output logic             video_input_enable_o
);

    // ========================================================
    // helpers
    // returns {read_active, write_active} for either bus family
    function automatic logic [1:0] access(input logic m68, input logic a, input logic b);
        access = m68 ? {a & b, a & !b} : {!b & a, !a & b};
    endfunction : access

    // 5-6-5 widened to 6-6-6 by repeating the top bit
    function automatic logic [17:0] expand565(input logic [15:0] w);
        expand565 = {w[15:11], w[15], w[10:5], w[4:0], w[4]};
    endfunction : expand565

    // ========================================================
    // pin synchronisers
    logic [27:0] pin_a_q, pin_b_q, pin_c_q;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pin_a_q <= lrc_pkg::PIN_RST;
            pin_b_q <= lrc_pkg::PIN_RST;
            pin_c_q <= lrc_pkg::PIN_RST;
        end else begin
            pin_a_q <= {chip_select_low_n_i, index_data_select_i, write_strobe_or_enable_i,
                        read_strobe_or_direction_i, serial_data_i, cpu_family_strap_i,
                        bus_width_strap_hi_i, bus_width_strap_mid_i, bus_width_strap_lo_i,
                        host_protocol_strap_i, parallel_data_lines_i};
            pin_b_q <= pin_a_q;
            pin_c_q <= pin_b_q;
        end
    end

    logic        cs_act, dcx, sdi, m68, rc_mode, serial;
    logic [2:0]  bw;
    logic [17:0] pdata;
    logic [1:0]  acc_now;
    logic        en_par, en_ser, sclk_rise;

    always_comb begin
        cs_act    = !pin_b_q[27];
        dcx       = pin_b_q[26];
        sdi       = pin_b_q[23];
        m68       = pin_b_q[22];
        bw        = pin_b_q[21:19];
        rc_mode   = pin_b_q[18];
        pdata     = pin_b_q[17:0];
        serial    = bw[2] & bw[1];
        acc_now   = access(m68, pin_b_q[25], pin_b_q[24]);
        en_par    = cs_act & rc_mode & !serial;
        en_ser    = cs_act & rc_mode & serial;
        sclk_rise = pin_b_q[26] & !pin_c_q[26];
    end

    // ========================================================
    // state
    lrc_pkg::lrc_par_t par_q, par_d;
    lrc_pkg::lrc_ser_t ser_q, ser_d;
    logic [17:0] hold_q, hold_d, acc_q, acc_d, wl_q, wl_d, rl_q, rl_d;
    logic [17:0] pdo_q, pdo_d, disp_q, disp_d;
    logic [7:0]  index_q, index_d, sr_q, sr_d;
    logic [15:0] rwd_q, rwd_d;
    logic [2:0]  bit_q, bit_d, fmt_q, fmt_d;
    logic [1:0]  cnt_q, cnt_d;
    logic        ser_sel_q, ser_sel_d, oe_q, oe_d, fmw_q, fmw_d, fmr_q, fmr_d;
    logic        rw_q, rw_d, rr_q, rr_d, ven_q, ven_d, load_q;

    logic        beat_v, beat_dcx, mode8, frame_memory, last, pix_done;
    logic [17:0] beat_d, pix;
    logic [15:0] word;
    logic [1:0]  need;
    logic [7:0]  byte_in;

    always_comb begin
        par_d     = par_q;
        ser_d     = ser_q;
        hold_d    = hold_q;
        acc_d     = acc_q;
        wl_d      = wl_q;
        rl_d      = fmr_q ? fm_rdata_i : rl_q;
        pdo_d     = pdo_q;
        index_d   = index_q;
        sr_d      = sr_q;
        rwd_d     = rwd_q;
        bit_d     = bit_q;
        fmt_d     = fmt_q;
        cnt_d     = cnt_q;
        ser_sel_d = ser_sel_q;
        fmw_d     = 1'b0;
        fmr_d     = 1'b0;
        rw_d      = 1'b0;
        rr_d      = 1'b0;
        beat_v    = 1'b0;
        beat_dcx  = 1'b0;
        beat_d    = lrc_pkg::PIX_RST;
        pix       = lrc_pkg::PIX_RST;
        word      = lrc_pkg::WORD_RST;
        pix_done  = 1'b0;
        byte_in   = {sr_q[6:0], sdi};

        // parallel transfers; a write is taken when its strobe ends
        case (par_q)
            lrc_pkg::PAR_IDLE: begin
                hold_d = pdata;
                if (en_par && acc_now[0]) begin
                    par_d = lrc_pkg::PAR_WRITE;
                end else if (en_par && acc_now[1]) begin
                    par_d = lrc_pkg::PAR_READ;
                    if (!dcx) begin
                        pdo_d = {2'b00, status_i};
                    end else if (index_q == lrc_pkg::IDX_FRAME) begin
                        pdo_d = rl_q;
                        fmr_d = 1'b1;
                    end else begin
                        pdo_d = {2'b00, reg_rdata_i};
                        rr_d  = 1'b1;
                    end
                end
            end
            lrc_pkg::PAR_WRITE: begin
                if (!en_par) begin
                    par_d = lrc_pkg::PAR_IDLE;
                end else if (acc_now[0]) begin
                    hold_d = pdata;
                end else begin
                    par_d    = lrc_pkg::PAR_IDLE;
                    beat_v   = 1'b1;
                    beat_dcx = dcx;
                    beat_d   = hold_q;
                end
            end
            lrc_pkg::PAR_READ: begin
                if (!en_par || !acc_now[1]) begin
                    par_d = lrc_pkg::PAR_IDLE;
                end
            end
            default: par_d = lrc_pkg::PAR_IDLE;
        endcase

        // serial link: start byte, then write bytes
        if (!en_ser) begin
            ser_d = lrc_pkg::SER_START;
            bit_d = lrc_pkg::BIT_RST;
        end else if (sclk_rise) begin
            sr_d  = byte_in;
            bit_d = bit_q + 3'd1;
            if (bit_q == 3'd7) begin
                case (ser_q)
                    lrc_pkg::SER_START: begin
                        ser_sel_d = byte_in[1];
                        if (byte_in[7:3] == SER_DEV_CODE && byte_in[2] == bw[0] && !byte_in[0]) begin
                            ser_d = lrc_pkg::SER_WRITE;
                        end else begin
                            ser_d = lrc_pkg::SER_SKIP;
                        end
                    end
                    lrc_pkg::SER_WRITE: begin
                        beat_v   = 1'b1;
                        beat_dcx = ser_sel_q;
                        beat_d   = {10'h000, byte_in};
                    end
                    lrc_pkg::SER_SKIP: ser_d = lrc_pkg::SER_SKIP;
                    default: ser_d = lrc_pkg::SER_SKIP;
                endcase
            end
        end

        // beat assembly into registers or pixels
        mode8 = serial || bw == lrc_pkg::BW_8;
        frame_memory  = index_q == lrc_pkg::IDX_FRAME;
        if (frame_memory) begin
            case (bw)
                lrc_pkg::BW_16P2_A, lrc_pkg::BW_16P2_B: need = 2'd2;
                lrc_pkg::BW_8: need = 2'd3;
                lrc_pkg::BW_16_65K, lrc_pkg::BW_18_A, lrc_pkg::BW_18_B: need = 2'd1;
                default: need = (fmt_q == lrc_pkg::FMT_565) ? 2'd2 : 2'd3;
            endcase
        end else begin
            need = mode8 ? 2'd2 : 2'd1;
        end
        last = (cnt_q + 2'd1) == need;
        if (beat_v) begin
            if (!beat_dcx) begin
                index_d = beat_d[7:0];
                cnt_d   = lrc_pkg::CNT_RST;
            end else if (!last) begin
                cnt_d = cnt_q + 2'd1;
                acc_d = mode8 ? {acc_q[9:0], beat_d[7:0]} : beat_d;
            end else begin
                cnt_d = lrc_pkg::CNT_RST;
                word  = mode8 ? {acc_q[7:0], beat_d[7:0]} : beat_d[15:0];
                if (frame_memory) begin
                    case (bw)
                        lrc_pkg::BW_16_65K: pix = expand565(beat_d[15:0]);
                        lrc_pkg::BW_16P2_A, lrc_pkg::BW_16P2_B: pix = {acc_q[15:0], beat_d[1:0]};
                        lrc_pkg::BW_18_A, lrc_pkg::BW_18_B: pix = beat_d;
                        default: pix = (serial && fmt_q == lrc_pkg::FMT_565) ? expand565(word)
                                     : {acc_q[15:10], acc_q[7:2], beat_d[7:2]};
                    endcase
                    pix_done = 1'b1;
                    wl_d     = pix;
                    fmw_d    = 1'b1;
                end else begin
                    rw_d  = 1'b1;
                    rwd_d = word;
                    if (index_q == lrc_pkg::IDX_PIXFMT) begin
                        fmt_d = word[2:0];
                    end
                end
            end
        end

        oe_d   = par_d == lrc_pkg::PAR_READ;
        ven_d  = load_q ? ven_q : otp_video_enable_i;
        disp_d = (ven_q && !partial_mode_i) ? video_pixel_i : frame_pixel_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            par_q     <= lrc_pkg::PAR_IDLE;
            ser_q     <= lrc_pkg::SER_START;
            hold_q    <= lrc_pkg::PIX_RST;
            acc_q     <= lrc_pkg::PIX_RST;
            wl_q      <= lrc_pkg::PIX_RST;
            rl_q      <= lrc_pkg::PIX_RST;
            pdo_q     <= lrc_pkg::PIX_RST;
            disp_q    <= lrc_pkg::PIX_RST;
            index_q   <= lrc_pkg::INDEX_RST;
            sr_q      <= lrc_pkg::BYTE_RST;
            rwd_q     <= lrc_pkg::WORD_RST;
            bit_q     <= lrc_pkg::BIT_RST;
            fmt_q     <= lrc_pkg::FMT_RST;
            cnt_q     <= lrc_pkg::CNT_RST;
            ser_sel_q <= 1'b0;
            oe_q      <= 1'b0;
            fmw_q     <= 1'b0;
            fmr_q     <= 1'b0;
            rw_q      <= 1'b0;
            rr_q      <= 1'b0;
            ven_q     <= 1'b0;
            load_q    <= 1'b0;
        end else begin
            par_q     <= par_d;
            ser_q     <= ser_d;
            hold_q    <= hold_d;
            acc_q     <= acc_d;
            wl_q      <= wl_d;
            rl_q      <= rl_d;
            pdo_q     <= pdo_d;
            disp_q    <= disp_d;
            index_q   <= index_d;
            sr_q      <= sr_d;
            rwd_q     <= rwd_d;
            bit_q     <= bit_d;
            fmt_q     <= fmt_d;
            cnt_q     <= cnt_d;
            ser_sel_q <= ser_sel_d;
            oe_q      <= oe_d;
            fmw_q     <= fmw_d;
            fmr_q     <= fmr_d;
            rw_q      <= rw_d;
            rr_q      <= rr_d;
            ven_q     <= ven_d;
            load_q    <= 1'b1;  // otp value taken once, in the first cycle after reset
        end
    end

    assign parallel_data_lines_o    = pdo_q;
    assign parallel_data_lines_oe_o = oe_q;
    assign reg_wr_o                 = rw_q;
    assign reg_rd_o                 = rr_q;
    assign reg_index_o              = index_q;
    assign reg_wdata_o              = rwd_q;
    assign fm_wr_o                  = fmw_q;
    assign fm_wdata_o               = wl_q;
    assign fm_rd_o                  = fmr_q;
    assign display_pixel_o          = disp_q;
    assign video_input_enable_o     = ven_q;

    // ========================================================
    // assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    property p_no_beat_without_cs;
        !cs_act || !rc_mode |-> !beat_v;
    endproperty
    a_no_beat_without_cs: assert property (p_no_beat_without_cs) else $error("beat while deselected");

    property p_index_load;
        beat_v && !beat_dcx |=> index_q == $past(beat_d[7:0]) && !fm_wr_o && !reg_wr_o;
    endproperty
    a_index_load: assert property (p_index_load) else $error("index pointer not loaded");

    property p_latch_commit;
        pix_done |=> fm_wr_o && fm_wdata_o == $past(pix) ##1 !fm_wr_o;
    endproperty
    a_latch_commit: assert property (p_latch_commit) else $error("write latch not committed");

    property p_read_latch_old;
        par_q == lrc_pkg::PAR_IDLE && fmr_d |=> parallel_data_lines_o == $past(rl_q) ##1 rl_q == $past(fm_rdata_i);
    endproperty
    a_read_latch_old: assert property (p_read_latch_old) else $error("read latch order wrong");

    property p_memory_source;
        !ven_q |=> display_pixel_o == $past(frame_pixel_i);
    endproperty
    a_memory_source: assert property (p_memory_source) else $error("video off but not memory");

    property p_video_source;
        ven_q && !partial_mode_i |=> display_pixel_o == $past(video_pixel_i);
    endproperty
    a_video_source: assert property (p_video_source) else $error("video pixel not shown");

    property p_otp_hold;
        load_q && $past(load_q) |-> $stable(video_input_enable_o);
    endproperty
    a_otp_hold: assert property (p_otp_hold) else $error("video enable changed");

    property p_drive_only_read;
        parallel_data_lines_oe_o |-> par_q == lrc_pkg::PAR_READ && $past(en_par);
    endproperty
    a_drive_only_read: assert property (p_drive_only_read) else $error("bus driven outside read");

    property p_eight_bit_three;
        pix_done && bw == lrc_pkg::BW_8 && !serial |-> cnt_q == 2'd2;
    endproperty
    a_eight_bit_three: assert property (p_eight_bit_three) else $error("8-bit pixel beat count");

    c_pixel_8bit: cover property (pix_done && bw == lrc_pkg::BW_8);
    c_frame_memory_read: cover property (fm_rd_o ##[1:20] fm_rd_o);
    c_serial_pixel: cover property (pix_done && serial);
    c_video_shown: cover property (ven_q && !partial_mode_i);

endmodule : lrc_host_port

// ==== verif/lrc_host_model.sv ====
`timescale 1ns/10ps
// ========================================================
// host processor on the far side of the parallel / serial bus
module lrc_host_model (
    input  wire logic        clk_i,
    input  wire logic        m68_i,
    input  wire logic [17:0] rdata_i,
    output logic             cs_n_o,
    output logic             sel_o,
    output logic             wr_en_o,
    output logic             rd_dir_o,
    output logic             ser_o,
    output logic      [17:0] wdata_o
);
    initial begin
        cs_n_o   = 1'b1;
        sel_o    = 1'b0;
        wr_en_o  = 1'b1;
        rd_dir_o = 1'b1;
        ser_o    = 1'b0;
        wdata_o  = 18'h0_0000;
    end

    // strobe encodings of both families; idle in m68 keeps enable low
    task automatic strobe(input logic act, input logic rd);
        wr_en_o  <= m68_i ? act : ~(act & ~rd);
        rd_dir_o <= m68_i ? (rd | ~act) : ~(act & rd);
    endtask : strobe

    // strobes held 6 cycles and released 7, well above the 3-cycle sync need
    task automatic xfer(input logic cs_n, input logic sel, input logic rd, input logic [17:0] wd,
                        output logic [17:0] q);
        @(posedge clk_i);
        #1;
        cs_n_o  <= cs_n;
        sel_o   <= sel;
        wdata_o <= rd ? ~wd : wd;
        strobe(1'b1, rd);
        repeat (6) @(posedge clk_i);
        #1;
        q = rdata_i;
        strobe(1'b0, rd);
        wdata_o <= ~wdata_o;
        repeat (7) @(posedge clk_i);
        #1;
        cs_n_o  <= 1'b1;
    endtask : xfer

    // serial frame, msb first; clock rests low and data toggles after the last bit, before chip select rises
    task automatic ser(input logic [31:0] b, input int nb);
        @(posedge clk_i);
        #1;
        cs_n_o <= 1'b0;
        for (int i = 0; i < nb * 8; i++) begin
            repeat (3) @(posedge clk_i);
            #1;
            sel_o <= 1'b0;
            ser_o <= b[31 - i];
            repeat (3) @(posedge clk_i);
            #1;
            sel_o <= 1'b1;
        end
        repeat (4) @(posedge clk_i);
        #1;
        sel_o  <= 1'b0;
        ser_o  <= ~ser_o;
        repeat (4) @(posedge clk_i);
        #1;
        cs_n_o <= 1'b1;
    endtask : ser
endmodule : lrc_host_model

// ==== verif/lrc_host_port_test.sv ====
`timescale 1ns/10ps
module lrc_host_port_test;
    localparam logic [4:0] DEV = 5'h15;  // arbitrary value
    logic        clk_sys_i, rst_n_i, rc, fam, otp, part;
    logic [2:0]  bw;
    logic [17:0] vpix, fpix, fm_rdata, pd_o, fm_wd, disp, fm_last, q, p;
    logic [15:0] reg_rdata, status, reg_wd, reg_last;
    logic [7:0]  idx;
    logic        cs_n, sel, wen, rdir, sdi, oe, reg_wr, reg_rd, fm_wr, fm_rd, ven;
    logic [17:0] hdata;
    int          err_total, check_count, fm_n, rd_n, rr_n, n;

    lrc_host_port #(.SER_DEV_CODE(DEV)) u_lrc_host_port (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .host_protocol_strap_i(rc), .cpu_family_strap_i(fam),
        .bus_width_strap_hi_i(bw[2]), .bus_width_strap_mid_i(bw[1]), .bus_width_strap_lo_i(bw[0]),
        .chip_select_low_n_i(cs_n), .index_data_select_i(sel), .write_strobe_or_enable_i(wen),
        .read_strobe_or_direction_i(rdir), .parallel_data_lines_i(hdata), .serial_data_i(sdi),
        .otp_video_enable_i(otp), .partial_mode_i(part), .video_pixel_i(vpix), .frame_pixel_i(fpix),
        .fm_rdata_i(fm_rdata), .reg_rdata_i(reg_rdata), .status_i(status),
        .parallel_data_lines_o(pd_o), .parallel_data_lines_oe_o(oe), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
        .reg_index_o(idx), .reg_wdata_o(reg_wd), .fm_wr_o(fm_wr), .fm_wdata_o(fm_wd), .fm_rd_o(fm_rd),
        .display_pixel_o(disp), .video_input_enable_o(ven));

    // the host only looks at the lines while the device drives them
    lrc_host_model u_lrc_host_model (
        .clk_i(clk_sys_i), .m68_i(fam), .rdata_i(oe ? pd_o : 18'h0_0000), .cs_n_o(cs_n), .sel_o(sel),
        .wr_en_o(wen), .rd_dir_o(rdir), .ser_o(sdi), .wdata_o(hdata));

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        if (fm_wr) begin
            fm_n++;
            fm_last = fm_wd;
        end
        if (reg_wr) reg_last = reg_wd;
        if (reg_rd) rr_n++;
        if (fm_rd) rd_n++;
    end

    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic reset(input logic ov);
        @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b0;
        otp     = ov;
        repeat (2) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1;
    endtask : reset

    task automatic straps(input logic r, input logic [3:0] s);
        @(posedge clk_sys_i);
        #1;
        rc  = r;
        {fam, bw} = s;
        // let the family pin settle so the model picks the new idle levels
        #1;
        u_lrc_host_model.strobe(1'b0, 1'b0);
        repeat (4) @(posedge clk_sys_i);
    endtask : straps

    task automatic wr(input logic s, input logic [17:0] d);
        u_lrc_host_model.xfer(1'b0, s, 1'b0, d, q);
    endtask : wr

    task automatic rd(input logic s);
        u_lrc_host_model.xfer(1'b0, s, 1'b1, 18'h0_0000, q);
    endtask : rd

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_total++;
        final_report();
    end

    initial begin
        {rst_n_i, rc, fam, bw, otp, part} = '0;
        {err_total, check_count, fm_n, rd_n, rr_n} = '0;
        vpix = 18'h1_2345;
        fpix = 18'h2_abcd;
        fm_rdata = 18'h1_5555;
        reg_rdata = 16'hbeef;
        status = 16'h0c3a;
        reset(1'b1);
        check(ven, 1'b1);
        check(idx, 8'h00);
        check(disp, vpix);
        part = 1'b1;
        repeat (3) @(posedge clk_sys_i);
        check(disp, fpix);
        $display("test video done");
        straps(1'b1, 4'b0010);
        wr(1'b0, 18'h0_0022);
        check(idx, 8'h22);
        n = fm_n;
        wr(1'b1, 18'h2_5a5a);
        check(fm_last, 18'h2_5a5a);
        u_lrc_host_model.xfer(1'b1, 1'b1, 1'b0, 18'h3_ffff, q);
        check(fm_n - n, 1);
        wr(1'b0, 18'h0_0010);
        wr(1'b1, 18'h0_1234);
        check(idx, 8'h10);
        check(reg_last, 16'h1234);
        rd(1'b0);
        check(q, {2'b00, status});
        n = rr_n;
        rd(1'b1);
        check(q, {2'b00, reg_rdata});
        check(rr_n - n, 1);
        wr(1'b0, 18'h0_0022);
        n = rd_n;
        rd(1'b1);
        rd(1'b1);
        check(q, fm_rdata);
        check(rd_n - n, 2);
        $display("test i80 done");
        straps(1'b1, 4'b1101);
        wr(1'b1, 18'h1_0f0f);
        check(fm_last, 18'h1_0f0f);
        p = 18'h3_c0f1;
        for (int k = 0; k < 2; k++) begin
            straps(1'b1, k ? 4'b0100 : 4'b0001);
            n = fm_n;
            wr(1'b1, {2'b00, p[17:2]});
            wr(1'b1, {16'h0000, p[1:0]});
            check(fm_n - n, 1);
            check(fm_last, p);
        end
        straps(1'b1, 4'b0011);
        p = 18'h1_5a3c;
        wr(1'b1, {10'h000, p[17:12], 2'b00});
        wr(1'b1, {10'h000, p[11:6], 2'b00});
        wr(1'b1, {10'h000, p[5:0], 2'b00});
        check(fm_last, p);
        straps(1'b1, 4'b0000);
        wr(1'b1, 18'h0_8541);
        check(fm_last, 18'h2_1a82);
        $display("test widths done");
        straps(1'b0, 4'b0010);
        n = fm_n;
        wr(1'b1, 18'h0_1111);
        check(fm_n - n, 0);
        straps(1'b1, 4'b0111);
        u_lrc_host_model.ser({DEV, 3'b100, 8'h10, 16'h0000}, 2);
        check(idx, 8'h10);
        u_lrc_host_model.ser({DEV, 3'b100, 8'h22, 16'h0000}, 2);
        p = 18'h2_9c47;
        u_lrc_host_model.ser({DEV, 3'b110, p[17:12], 2'b00, p[11:6], 2'b00, p[5:0], 2'b00}, 4);
        check(fm_last, p);
        n = fm_n;
        u_lrc_host_model.ser({~DEV, 3'b110, 24'hfcfcfc}, 4);
        check(fm_n - n, 0);
        // pixel format register to 5-6-5, then a two-byte pixel
        u_lrc_host_model.ser({DEV, 3'b100, 8'h3A, 16'h0000}, 2);
        u_lrc_host_model.ser({DEV, 3'b110, 16'h0005, 8'h00}, 3);
        check(reg_last, 16'h0005);
        u_lrc_host_model.ser({DEV, 3'b100, 8'h22, 16'h0000}, 2);
        u_lrc_host_model.ser({DEV, 3'b110, 16'h8541, 8'h00}, 3);
        check(fm_last, 18'h2_1a82);
        $display("test serial done");
        reset(1'b0);
        part = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        check(ven, 1'b0);
        check(disp, fpix);
        $display("test otp clear done");
        final_report();
    end
endmodule : lrc_host_port_test
